/* File: src/spp_pkg.sv */
// Shared constants, register map and types of the serial packet packer.
package spp_pkg;

	// ----------------------------------------------------------------
	// Data path sizes
	// ----------------------------------------------------------------
	localparam int DATA_W     = 8;
	localparam int BUF_BYTES  = 1024;
	localparam int CNT_W      = 11;
	localparam int PTR_W      = 10;
	localparam int FIFO_DEPTH = 16;
	localparam int IDLE_W     = 16;
	localparam int PKTCNT_W   = 16;

	// ----------------------------------------------------------------
	// Register map, byte addresses of aligned 32-bit words
	// ----------------------------------------------------------------
	localparam int          ADDR_W     = 8;
	localparam int          REG_W      = 32;
	localparam logic [7:0]  OFS_CTRL   = 8'h00;
	localparam logic [7:0]  OFS_DELIM  = 8'h04;
	localparam logic [7:0]  OFS_PKTLEN = 8'h08;
	localparam logic [7:0]  OFS_IDLE   = 8'h0c;
	localparam logic [7:0]  OFS_STATUS = 8'h10;
	localparam logic [7:0]  OFS_PKTCNT = 8'h14;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_D1_EN    = 0;
	localparam int CTRL_D2_EN    = 1;
	localparam int CTRL_MODE_LSB = 2;
	localparam int CTRL_W        = 4;
	localparam int DELIM_D2_LSB  = 8;
	localparam int STAT_BUSY     = 16;
	localparam int STAT_WAIT_LSB = 20;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [CTRL_W-1:0] CTRL_RST   = 4'h0;
	localparam logic [7:0]        DELIM_RST  = 8'h00;
	localparam logic [CNT_W-1:0]  PKTLEN_RST = 11'h000;
	localparam logic [IDLE_W-1:0] IDLE_RST   = 16'h0000;

	// ----------------------------------------------------------------
	// Timing: one millisecond tick at a 10 ns clock
	// ----------------------------------------------------------------
	localparam int MS_TIME_MS     = 1;
	localparam int NS_PER_MS      = 1000000;
	localparam int CLK_PERIOD_NS  = 10;
	localparam int MS_CYCLES_DFLT =
		(MS_TIME_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_W         = 17;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_PASS  = 2'h0,
		MODE_PLUS1 = 2'h1,
		MODE_PLUS2 = 2'h2,
		MODE_STRIP = 2'h3
	} spp_mode_t;

	typedef enum logic [1:0] {
		ST_FILL  = 2'b01,
		ST_DRAIN = 2'b10
	} spp_state_t;

	function automatic logic spp_match(input logic [7:0] a,
	                                   input logic [7:0] b);
		return a == b;
	endfunction

endpackage

/* File: src/spp_stream_if.sv */
// Valid/ready byte stream between the packer and its input FIFO.
interface spp_stream_if #(parameter int W = 8);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface

/* File: src/spp_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
module spp_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Filling side
	spp_stream_if.snk in_s,
	// Draining side
	spp_stream_if.src out_s
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wp_reg, wp_next;
	logic [AW-1:0] rp_reg, rp_next;
	logic [AW:0]   cnt_reg, cnt_next;
	logic          rdy_reg, rdy_next;
	logic          push;
	logic          pop;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		push     = in_s.valid & rdy_reg;
		pop      = out_s.ready & (cnt_reg != '0);
		wp_next  = push ? wp_reg + 1'b1 : wp_reg;
		rp_next  = pop ? rp_reg + 1'b1 : rp_reg;
		cnt_next = cnt_reg;
		if (push & ~pop) begin
			cnt_next = cnt_reg + 1'b1;
		end else if (pop & ~push) begin
			cnt_next = cnt_reg - 1'b1;
		end
		// Ready is registered so the filling side sees a clean flop.
		rdy_next = cnt_next != (AW+1)'(DEPTH);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
			rdy_reg <= 1'b1;
		end else begin
			wp_reg  <= wp_next;
			rp_reg  <= rp_next;
			cnt_reg <= cnt_next;
			rdy_reg <= rdy_next;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_reg] <= in_s.data;
		end
	end

	assign in_s.ready  = rdy_reg;
	assign out_s.valid = cnt_reg != '0;
	assign out_s.data  = mem[rp_reg];
endmodule

/* File: src/spp_packer.sv */
// Serial packet packer: gathers received bytes and cuts them into packets.
// Contract
// - Length setting zero disables length cuts; delimiter or full buffer cut.
// - Nonzero length setting cuts a packet once the byte count reaches it.
// - First delimiter alone: that single byte value is the delimiter.
// - Both delimiters: first byte immediately followed by second is the match.
// - With delimiters on, bytes accumulate until buffer full or match.
// - Delimiter handling mode is ignored unless first delimiter is enabled.
// - Pass mode cuts at once and keeps the delimiter bytes in the packet.
// - Plus-one mode waits one more byte, then cuts including it.
// - Plus-two mode waits two more bytes, then cuts including them.
// - Strip mode cuts at the match but drops the delimiter bytes.
// - Idle timeout zero never flushes; data waits indefinitely.
// - Nonzero idle timeout flushes after that many ms without a byte.
module spp_packer #(
	parameter int unsigned MS_CYCLES = spp_pkg::MS_CYCLES_DFLT
) (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         rst,
	// Register port
	input  wire logic [spp_pkg::ADDR_W-1:0]   reg_addr,
	input  wire logic [spp_pkg::REG_W-1:0]    reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [spp_pkg::REG_W-1:0]    reg_rdata,
	// Received characters
	input  wire logic                         rx_valid,
	input  wire logic [spp_pkg::DATA_W-1:0]   rx_data,
	output logic                              rx_ready,
	// Packet stream toward the network side
	output logic                              tx_valid,
	output logic      [spp_pkg::DATA_W-1:0]   tx_data,
	output logic                              tx_last,
	input  wire logic                         tx_ready
);
	import spp_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [CTRL_W-1:0]   ctrl_reg, ctrl_next;
	logic [7:0]          delim1_reg, delim1_next;
	logic [7:0]          delim2_reg, delim2_next;
	logic [CNT_W-1:0]    pktlen_reg, pktlen_next;
	logic [IDLE_W-1:0]   idle_reg, idle_next;
	logic [REG_W-1:0]    rdata_reg, rdata_next;

	spp_state_t          state_reg, state_next;
	logic [CNT_W-1:0]    cnt_reg, cnt_next;
	logic [1:0]          wait_reg, wait_next;
	logic                prev_d1_reg, prev_d1_next;
	logic [CNT_W-1:0]    drain_len_reg, drain_len_next;
	logic [CNT_W-1:0]    rd_ptr_reg, rd_ptr_next;
	logic [TICK_W-1:0]   tick_reg, tick_next;
	logic [IDLE_W-1:0]   idle_cnt_reg, idle_cnt_next;
	logic [PKTCNT_W-1:0] pktcnt_reg, pktcnt_next;
	logic                tx_valid_reg, tx_valid_next;
	logic [DATA_W-1:0]   tx_data_reg, tx_data_next;
	logic                tx_last_reg, tx_last_next;

	logic [DATA_W-1:0]   buf_mem [BUF_BYTES];
	logic                pop;
	logic                emit;
	logic                d1_en;
	logic                two_en;
	logic                hit;
	logic                load;
	logic [CNT_W-1:0]    cnt_inc;
	logic [CNT_W-1:0]    keep_len;
	logic [CNT_W-1:0]    dlen;
	spp_mode_t           mode;

	spp_stream_if #(.W(DATA_W)) in_s();
	spp_stream_if #(.W(DATA_W)) fo_s();

	// ----------------------------------------------------------------
	// Input FIFO; a stalled packer back-pressures the receiver
	// ----------------------------------------------------------------
	assign in_s.valid = rx_valid;
	assign in_s.data  = rx_data;
	assign rx_ready   = in_s.ready;

	spp_fifo #(
		.W     (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk   (clk),
		.rst   (rst),
		.in_s  (in_s),
		.out_s (fo_s)
	);

	// Bytes are taken only while filling, never while a packet drains.
	assign pop        = (state_reg == ST_FILL) & fo_s.valid;
	assign fo_s.ready = pop;

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_next   = ctrl_reg;
		delim1_next = delim1_reg;
		delim2_next = delim2_reg;
		pktlen_next = pktlen_reg;
		idle_next   = idle_reg;
		rdata_next  = '0;
		if (reg_wr) begin
			unique case (reg_addr)
				OFS_CTRL: begin
					ctrl_next = reg_wdata[CTRL_W-1:0];
				end
				OFS_DELIM: begin
					delim1_next = reg_wdata[7:0];
					delim2_next = reg_wdata[DELIM_D2_LSB +: 8];
				end
				OFS_PKTLEN: begin
					pktlen_next = reg_wdata[CNT_W-1:0];
				end
				OFS_IDLE: begin
					idle_next = reg_wdata[IDLE_W-1:0];
				end
				default: begin
				end
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				OFS_CTRL: begin
					rdata_next[CTRL_W-1:0] = ctrl_reg;
				end
				OFS_DELIM: begin
					rdata_next[7:0]               = delim1_reg;
					rdata_next[DELIM_D2_LSB +: 8] = delim2_reg;
				end
				OFS_PKTLEN: begin
					rdata_next[CNT_W-1:0] = pktlen_reg;
				end
				OFS_IDLE: begin
					rdata_next[IDLE_W-1:0] = idle_reg;
				end
				OFS_STATUS: begin
					rdata_next[CNT_W-1:0]          = cnt_reg;
					rdata_next[STAT_BUSY]          = state_reg == ST_DRAIN;
					rdata_next[STAT_WAIT_LSB +: 2] = wait_reg;
				end
				OFS_PKTCNT: begin
					rdata_next[PKTCNT_W-1:0] = pktcnt_reg;
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Packing and draining
	// ----------------------------------------------------------------
	always_comb begin
		d1_en  = ctrl_reg[CTRL_D1_EN];
		two_en = d1_en & ctrl_reg[CTRL_D2_EN];
		mode   = spp_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);
		dlen   = two_en ? CNT_W'(2) : CNT_W'(1);
		cnt_inc  = cnt_reg + 1'b1;
		keep_len = cnt_inc;
		emit     = 1'b0;
		hit      = 1'b0;

		state_next     = state_reg;
		cnt_next       = cnt_reg;
		wait_next      = wait_reg;
		prev_d1_next   = prev_d1_reg;
		drain_len_next = drain_len_reg;
		rd_ptr_next    = rd_ptr_reg;
		tick_next      = tick_reg;
		idle_cnt_next  = idle_cnt_reg;
		pktcnt_next    = pktcnt_reg;

		if (pop) begin
			cnt_next      = cnt_inc;
			tick_next     = '0;
			idle_cnt_next = '0;
			if (two_en) begin
				hit = prev_d1_reg & spp_match(fo_s.data, delim2_reg);
			end else begin
				hit = d1_en & spp_match(fo_s.data, delim1_reg);
			end
			prev_d1_next = two_en & spp_match(fo_s.data, delim1_reg);
			if (wait_reg != 2'h0) begin
				// Further matches are not looked at while trailing bytes
				// are being collected.
				wait_next = wait_reg - 1'b1;
				emit      = wait_reg == 2'h1;
			end else if (hit) begin
				unique case (mode)
					MODE_PASS: begin
						emit = 1'b1;
					end
					MODE_PLUS1: begin
						wait_next = 2'h1;
					end
					MODE_PLUS2: begin
						wait_next = 2'h2;
					end
					MODE_STRIP: begin
						emit     = 1'b1;
						keep_len = cnt_inc - dlen;
					end
				endcase
			end
			if (cnt_inc == CNT_W'(BUF_BYTES)) begin
				emit = 1'b1;
			end
			if ((pktlen_reg != '0) && (cnt_inc >= pktlen_reg)) begin
				emit = 1'b1;
			end
		end else if ((state_reg == ST_FILL) && (cnt_reg != '0)) begin
			if (tick_reg == TICK_W'(MS_CYCLES - 1)) begin
				tick_next = '0;
				if (idle_cnt_reg != '1) begin
					idle_cnt_next = idle_cnt_reg + 1'b1;
				end
			end else begin
				tick_next = tick_reg + 1'b1;
			end
			// A zero timeout never fires, whatever the count.
			if ((idle_reg != '0) && (idle_cnt_reg >= idle_reg)) begin
				emit     = 1'b1;
				keep_len = cnt_reg;
			end
		end else begin
			tick_next     = '0;
			idle_cnt_next = '0;
		end

		if (emit) begin
			cnt_next      = '0;
			wait_next     = 2'h0;
			prev_d1_next  = 1'b0;
			tick_next     = '0;
			idle_cnt_next = '0;
			// A strip that leaves nothing sends no empty packet.
			if (keep_len != '0) begin
				state_next     = ST_DRAIN;
				drain_len_next = keep_len;
				rd_ptr_next    = '0;
				pktcnt_next    = pktcnt_reg + 1'b1;
			end
		end

		load          = ~tx_valid_reg | tx_ready;
		tx_valid_next = tx_valid_reg & ~tx_ready;
		tx_data_next  = tx_data_reg;
		tx_last_next  = tx_last_reg;
		if ((state_reg == ST_DRAIN) && load) begin
			tx_valid_next = 1'b1;
			tx_data_next  = buf_mem[rd_ptr_reg[PTR_W-1:0]];
			tx_last_next  = rd_ptr_reg == drain_len_reg - 1'b1;
			rd_ptr_next   = rd_ptr_reg + 1'b1;
			if (rd_ptr_reg == drain_len_reg - 1'b1) begin
				state_next = ST_FILL;
			end
		end
	end

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_reg      <= CTRL_RST;
			delim1_reg    <= DELIM_RST;
			delim2_reg    <= DELIM_RST;
			pktlen_reg    <= PKTLEN_RST;
			idle_reg      <= IDLE_RST;
			rdata_reg     <= '0;
			state_reg     <= ST_FILL;
			cnt_reg       <= '0;
			wait_reg      <= 2'h0;
			prev_d1_reg   <= 1'b0;
			drain_len_reg <= '0;
			rd_ptr_reg    <= '0;
			tick_reg      <= '0;
			idle_cnt_reg  <= '0;
			pktcnt_reg    <= '0;
			tx_valid_reg  <= 1'b0;
			tx_data_reg   <= '0;
			tx_last_reg   <= 1'b0;
		end else begin
			ctrl_reg      <= ctrl_next;
			delim1_reg    <= delim1_next;
			delim2_reg    <= delim2_next;
			pktlen_reg    <= pktlen_next;
			idle_reg      <= idle_next;
			rdata_reg     <= rdata_next;
			state_reg     <= state_next;
			cnt_reg       <= cnt_next;
			wait_reg      <= wait_next;
			prev_d1_reg   <= prev_d1_next;
			drain_len_reg <= drain_len_next;
			rd_ptr_reg    <= rd_ptr_next;
			tick_reg      <= tick_next;
			idle_cnt_reg  <= idle_cnt_next;
			pktcnt_reg    <= pktcnt_next;
			tx_valid_reg  <= tx_valid_next;
			tx_data_reg   <= tx_data_next;
			tx_last_reg   <= tx_last_next;
		end
	end

	// The packet buffer has no reset; the count says what is valid.
	always_ff @(posedge clk) begin
		if (pop) begin
			buf_mem[cnt_reg[PTR_W-1:0]] <= fo_s.data;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata = rdata_reg;
	assign tx_valid  = tx_valid_reg;
	assign tx_data   = tx_data_reg;
	assign tx_last   = tx_last_reg;
endmodule

/* File: verif/spp_monitor.sv */
// Port-level checks of the serial packet packer.
module spp_monitor #(
	parameter int unsigned MS_CYCLES = 10
) (
	// Clock and reset
	input wire logic                       clk,
	input wire logic                       rst,
	// Register port
	input wire logic [spp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [spp_pkg::REG_W-1:0]  reg_wdata,
	input wire logic                       reg_wr,
	input wire logic                       reg_rd,
	input wire logic [spp_pkg::REG_W-1:0]  reg_rdata,
	// Streams
	input wire logic                       rx_valid,
	input wire logic                       rx_ready,
	input wire logic                       tx_valid,
	input wire logic [spp_pkg::DATA_W-1:0] tx_data,
	input wire logic                       tx_last,
	input wire logic                       tx_ready
);
	import spp_pkg::*;
	// ----------------------------------------------------------------
	// Shadow settings
	// ----------------------------------------------------------------
	// Shadows load on the same write edge as the packer's own registers, so they are exact.
	logic [3:0]  ctl;
	logic [15:0] dlm;
	logic [15:0] ish;
	logic [10:0] plen;
	logic [10:0] ocnt;
	logic [1:0]  pend;
	logic [31:0] quiet;
	logic        hs;
	logic        d1;
	assign hs = tx_valid && tx_ready;
	assign d1 = ctl[0] && !ctl[1];
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctl <= 4'h0;
			dlm <= 16'h0000;
			ish <= 16'h0000;
			plen <= 11'h000;
			ocnt <= 11'h000;
			pend <= 2'h0;
			quiet <= 32'h0;
		end else begin
			if (reg_wr && reg_addr == OFS_CTRL) ctl <= reg_wdata[3:0];
			if (reg_wr && reg_addr == OFS_DELIM) dlm <= reg_wdata[15:0];
			if (reg_wr && reg_addr == OFS_PKTLEN) plen <= reg_wdata[10:0];
			if (reg_wr && reg_addr == OFS_IDLE) ish <= reg_wdata[15:0];
			quiet <= (rx_valid && rx_ready) ? 32'h0 : quiet + 32'h1;
			if (hs) ocnt <= tx_last ? 11'h000 : ocnt + 11'h001;
			if (hs && pend != 2'h0)
				pend <= pend - 2'h1;
			else if (hs && d1 && !tx_last && tx_data == dlm[7:0]
				&& ^ctl[3:2])
				pend <= ctl[3:2];
		end
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 0)
		else $error("read data not zero outside a read answer");
	a_tx_hold: assert property (tx_valid && !tx_ready
		|=> tx_valid && $stable({tx_data, tx_last}))
		else $error("packet byte changed before it was taken");
	a_len_bound: assert property (tx_valid && plen != 0 |-> ocnt < plen)
		else $error("packet longer than the length setting");
	a_full_bound: assert property (tx_valid |-> ocnt < BUF_BYTES)
		else $error("packet longer than the buffer");
	a_pass_cut: assert property (tx_valid && d1 && ctl[3:2] == 2'h0
		&& tx_data == dlm[7:0] |-> tx_last)
		else $error("pass mode delimiter not last in packet");
	a_strip_drop: assert property (tx_valid && d1
		&& ctl[3:2] == 2'h3 |-> tx_data != dlm[7:0])
		else $error("strip mode let a delimiter through");
	a_pair_cut: assert property (tx_valid && tx_last && ctl == 4'h3
		&& ish == 0 && plen == 0 |-> tx_data == dlm[15:8])
		else $error("pair match packet does not end on second byte");
	a_plus_last: assert property (hs && pend == 2'h1 && ish == 0
		&& plen == 0 |-> tx_last)
		else $error("trailing byte count after delimiter wrong");
	a_idle_flush: assert property ($rose(tx_valid) && ish != 0
		&& plen == 0 && !ctl[0] |-> quiet >= ish * MS_CYCLES
		&& quiet <= ish * MS_CYCLES + 12)
		else $error("idle flush outside its time window");
	c_rx_full: cover property ($fell(rx_ready));
	c_pkt_end: cover property (hs && tx_last);
	c_idle_cut: cover property ($rose(tx_valid) && ish != 0);
endmodule

bind spp_packer spp_monitor #(.MS_CYCLES(MS_CYCLES)) u_spp_monitor (
	.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.rx_valid(rx_valid), .rx_ready(rx_ready), .tx_valid(tx_valid),
	.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready)
);

/* File: verif/spp_rx_model.sv */
// Serial device model that feeds queued bytes into the packer.
module spp_rx_model (
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// Pacing: one idle cycle between bytes when set
	input wire logic       slow,
	// Character stream
	output logic           rx_valid,
	output logic     [7:0] rx_data,
	input wire logic       rx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] q[$];
	logic       gap;
	task automatic put(input logic [7:0] b);
		q.push_back(b);
	endtask
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
	end
	// Idle data toggles every cycle so a stale byte never passes as new.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
			gap <= 1'b0;
		end else if (rx_valid && !rx_ready) begin
			gap <= 1'b0;
		end else if (q.size() != 0 && (!slow || gap)) begin
			rx_valid <= 1'b1;
			rx_data <= q.pop_front();
			gap <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			rx_data <= ~rx_data;
			gap <= 1'b1;
		end
	end
endmodule

/* File: verif/spp_packer_tb.sv */
// Self-checking bench of the serial packet packer.
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
	error_cnt++; $display("[ERR] %s exp %h got %h", n, e, g); end end

module spp_packer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import spp_pkg::*;
	localparam int unsigned MS = 10;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic [ADDR_W-1:0] reg_addr = 8'h00;
	logic [REG_W-1:0]  reg_wdata = 32'h0;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic [REG_W-1:0]  reg_rdata;
	logic              rx_valid;
	logic [7:0]        rx_data;
	logic              rx_ready;
	logic              tx_valid;
	logic [7:0]        tx_data;
	logic              tx_last;
	logic              tx_ready = 1'b1;
	logic              slow = 1'b0;
	logic              saw_full = 1'b0;
	logic [8:0]        got_q[$];
	logic [8:0]        exp_q[$];
	int                error_cnt = 0;
	int                check_count = 0;
	int                cyc = 0;
	logic [7:0]        ofs[7] = '{OFS_CTRL, OFS_DELIM, OFS_PKTLEN,
		OFS_IDLE, OFS_STATUS, OFS_PKTCNT, 8'h20};
	logic [7:0]        pr[5] = '{8'h0a, 8'h0d, 8'h42, 8'h0d, 8'h0a};

	always #5 clk = ~clk;

	spp_packer #(.MS_CYCLES(MS)) u_spp_packer (
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.tx_ready(tx_ready)
	);
	spp_rx_model u_spp_rx_model (
		.clk(clk), .rst(rst), .slow(slow), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_ready(rx_ready)
	);

	always @(posedge clk) begin
		if (tx_valid === 1'b1 && tx_ready) got_q.push_back({tx_last, tx_data});
		if (!rst && rx_ready === 1'b0) saw_full <= 1'b1;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 `CHK("reg_rdata", e, reg_rdata)
	endtask
	task automatic tx(input logic [7:0] b, input logic l);
		u_spp_rx_model.put(b);
		exp_q.push_back({l, b});
	endtask
	// Waits for the expected bytes, then a little longer to catch extras.
	task automatic settle(input string n);
		int i;
		i = 0;
		while (got_q.size() < exp_q.size() && i < 3000) begin
			@(posedge clk);
			i++;
		end
		repeat (10) @(posedge clk);
		`CHK("pkt_bytes", exp_q.size(), got_q.size())
		foreach (exp_q[k]) `CHK(n, exp_q[k], got_q[k])
		exp_q.delete();
		got_q.delete();
		$display("test %s done", n);
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		foreach (ofs[i]) rd(ofs[i], 32'h0);
		wr(OFS_PKTCNT, 32'h5);
		rd(OFS_PKTCNT, 32'h0);
		$display("test regs done");
		// Sink stalls so the input FIFO fills and refuses.
		wr(OFS_PKTLEN, 32'h3);
		tx_ready <= 1'b0;
		for (int i = 0; i < 24; i++) tx(8'(i), i % 3 == 2);
		repeat (60) @(posedge clk);
		`CHK("rx_full", 1'b1, saw_full)
		tx_ready <= 1'b1;
		settle("length");
		rd(OFS_PKTCNT, 32'h8);
		wr(OFS_PKTLEN, 32'h0);
		wr(OFS_DELIM, 32'h0a0d);
		rd(OFS_DELIM, 32'h0a0d);
		for (int m = 0; m < 4; m++) begin
			wr(OFS_CTRL, 32'({m[1:0], 2'b01}));
			tx(8'h41, m == 3);
			if (m == 3) u_spp_rx_model.put(8'h0d);
			else tx(8'h0d, m == 0);
			if (m == 1 || m == 2) tx(8'h0d, m == 1);
			if (m == 2) tx(8'h42, 1'b1);
			if (m == 3) u_spp_rx_model.put(8'h0d);
			settle("delimiter");
		end
		slow <= 1'b1;
		wr(OFS_CTRL, 32'h3);
		foreach (pr[i]) tx(pr[i], i == 4);
		settle("pair");
		slow <= 1'b0;
		wr(OFS_CTRL, 32'he);
		rd(OFS_CTRL, 32'he);
		wr(OFS_PKTLEN, 32'h2);
		tx(8'h0d, 1'b0);
		tx(8'h0a, 1'b1);
		settle("mode_off");
		wr(OFS_PKTLEN, 32'h0);
		wr(OFS_DELIM, 32'hff);
		wr(OFS_CTRL, 32'h1);
		for (int i = 0; i < BUF_BYTES; i++) tx(8'(i % 255), i == BUF_BYTES - 1);
		settle("full");
		wr(OFS_CTRL, 32'h0);
		wr(OFS_IDLE, 32'h2);
		rd(OFS_IDLE, 32'h2);
		tx(8'h66, 1'b0);
		repeat (15) @(posedge clk);
		tx(8'h67, 1'b1);
		repeat (15) @(posedge clk);
		`CHK("idle_early", 0, got_q.size())
		settle("idle");
		wr(OFS_IDLE, 32'h0);
		tx(8'h55, 1'b0);
		repeat (300) @(posedge clk);
		`CHK("idle_hold", 0, got_q.size())
		wr(OFS_PKTLEN, 32'h2);
		tx(8'h56, 1'b1);
		settle("hold");
		// One byte left waiting; a reset in mid-run must drop it.
		u_spp_rx_model.put(8'h31);
		repeat (10) @(posedge clk);
		rd(OFS_STATUS, 32'h1);
		@(posedge clk);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(OFS_STATUS, 32'h0);
		rd(OFS_PKTLEN, 32'h0);
		rd(OFS_CTRL, 32'h0);
		$display("test reset done");
		end_of_test();
	end
endmodule
